//--- hw/ext_int_pkg.sv
// package: register map, field layout and carrier types of the external interrupt latch
package ext_int_pkg;
  // byte offsets on the wishbone slave
  localparam logic [3:0] STATUS_CONTROL_OFS = 4'h0;
  localparam logic [3:0] EVENT_STATUS_OFS   = 4'h4;
  localparam logic [3:0] EVENT_MASK_OFS     = 4'h8;
  localparam logic [3:0] VECTOR_OFS         = 4'hC;
  // status and control field positions
  localparam int MODE_BIT    = 0;
  localparam int MASK_BIT    = 1;
  localparam int ACK_BIT     = 2;
  localparam int PENDING_BIT = 3;
  // event status field positions
  localparam int EV_LATCH_BIT = 0;
  localparam int EV_CLEAR_BIT = 1;
  localparam int EV_COUNT     = 2;
  // vector locations
  localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFFA;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFFB;
  // reset values
  localparam logic        MODE_RST  = 1'b0;
  localparam logic        MASK_RST  = 1'b0;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        mode;
    logic        mask;
    logic        latch;
  } ctrl_t;
endpackage

//--- hw/pin_edge_detect.sv
// falling edge detector for the active low interrupt pin
`timescale 1ns/1ps
module pin_edge_detect
  import ext_int_pkg::*;
(
  input  wire logic core_clk,      // bus clock
  input  wire logic sys_rst,       // synchronous reset, high
  input  wire logic pinLevel,      // pin, sampled synchronously
  output logic      pinPrev,       // registered pin sample
  output logic      fallEdge       // high-to-low seen this cycle
);
  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t st_q;
  edge_state_t st_d;

  always_comb begin
    st_d.prev = pinLevel;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // track the pin so a low held through reset is no edge
      st_q.prev <= pinLevel;
    end else begin
      st_q <= st_d;
    end
  end

  assign pinPrev  = st_q.prev;
  assign fallEdge = st_q.prev & ~pinLevel;

  chk_edge_from_sample: assert property (@(posedge core_clk) disable iff (sys_rst)
    fallEdge |-> $past(pinLevel) && !pinLevel)
    else $error("falling edge without high then low sample");
endmodule

//--- hw/event_irq.sv
// sticky event flags with mask and one level interrupt
`timescale 1ns/1ps
module event_irq
  import ext_int_pkg::*;
#(
  parameter int N = EV_COUNT
)
(
  input  wire logic         core_clk,    // bus clock
  input  wire logic         sys_rst,     // synchronous reset, high
  input  wire logic [N-1:0] eventIn,     // one-cycle event pulses
  input  wire logic [N-1:0] clearOnes,   // write one to clear
  input  wire logic         maskWe,      // mask write strobe
  input  wire logic [N-1:0] maskData,    // new mask value
  output logic [N-1:0]      statusQ,     // sticky flags
  output logic [N-1:0]      maskQ,       // mask, one enables
  output logic              eventIrq     // level interrupt
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
  } ev_state_t;

  ev_state_t    st_q;
  ev_state_t    st_d;
  logic [N-1:0] statusNext;

  // set wins over clear, per bit
  genvar i;
  for (i = 0; i < N; i++) begin : g_bit
    assign statusNext[i] = eventIn[i] | (st_q.status[i] & ~clearOnes[i]);
  end

  always_comb begin
    st_d        = st_q;
    st_d.status = statusNext;
    if (maskWe) begin
      st_d.mask = maskData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign statusQ  = st_q.status;
  assign maskQ    = st_q.mask;
  assign eventIrq = |(st_q.status & st_q.mask);

  chk_event_set_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
    |eventIn |=> |statusQ)
    else $error("event pulse did not set status");
endmodule

//--- hw/external_interrupt_latch.sv
// external interrupt latch with wishbone status and control registers
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Overview of operation
// - a falling edge, or low level in level mode, sets the request latch
// - a vector fetch acknowledge clears the latch
// - writing one to the acknowledge bit clears the latch, break permitting
// - reset clears the latch and sensitivity bit even with pin low
// - edge mode: only falling edges set; any acknowledge clears at once
// - level mode: pending while pin low; clears after acknowledge and pin high
// - mask bit at one withholds the request from priority logic
// - pending flag reads the latch state regardless of mask
// - a falling edge after an acknowledge latches a fresh request
// - serviced request vectors through locations FFFA and FFFB
// - acknowledge bit is write-only, reads zero, reset clears it
// - sensitivity bit is read-write: zero edge, one edge plus level
// - break blocks acknowledge writes unless clear-enable; clears persist
module external_interrupt_latch
  import ext_int_pkg::*;
(
  input  wire logic        core_clk,           // bus clock, 10 MHz
  input  wire logic        sys_rst,            // synchronous reset, high
  input  wire logic        wb_cyc_i,           // wishbone cycle
  input  wire logic        wb_stb_i,           // wishbone strobe
  input  wire logic        wb_we_i,            // wishbone write
  input  wire logic [3:0]  wb_adr_i,           // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,           // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,           // wishbone write data
  output logic [31:0]      wb_dat_o,           // wishbone read data
  output logic             wb_ack_o,           // wishbone acknowledge
  output logic             wb_err_o,           // unmapped address answer
  input  wire logic        ext_int_pin_n,      // interrupt pin, low active
  input  wire logic        vectorFetch,        // cpu fetching this vector
  input  wire logic        breakState,         // cpu in break state
  input  wire logic        break_clear_enable, // allows clears during break
  output logic             cpuIrqReq,          // request to priority logic
  output logic [15:0]      vectorHiAddr,       // vector high byte location
  output logic [15:0]      vectorLoAddr,       // vector low byte location
  output logic             eventIrq            // event interrupt, level
);
  typedef struct packed {
    ctrl_t       ctrl;
    logic        held;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;

  logic       pinPrev;
  logic       fallEdge;
  logic [1:0] evStatus;
  logic [1:0] evMask;
  logic [1:0] evPulse;
  logic [1:0] evClear;
  logic       maskWe;
  logic       req;
  logic       wrAccess;
  logic       swAck;
  logic       anyAck;
  logic       setReq;
  logic       mapped;
  logic       heldNext;
  logic       levelLow;
  logic       latchNext;

  pin_edge_detect u_edge (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pinLevel (ext_int_pin_n),
    .pinPrev  (pinPrev),
    .fallEdge (fallEdge)
  );

  assign req      = wb_cyc_i & wb_stb_i & ~st_q.ack & ~st_q.err;
  assign wrAccess = req & wb_we_i & wb_sel_i[0];
  assign mapped   = (wb_adr_i == STATUS_CONTROL_OFS) | (wb_adr_i == EVENT_STATUS_OFS)
                  | (wb_adr_i == EVENT_MASK_OFS) | (wb_adr_i == VECTOR_OFS);

  // software acknowledge, gated during break
  assign swAck  = wrAccess & (wb_adr_i == STATUS_CONTROL_OFS) & wb_dat_i[ACK_BIT]
                & (~breakState | break_clear_enable);
  assign anyAck = swAck | vectorFetch;

  // edge latch keeps an acknowledge given while the pin is still low
  assign levelLow  = st_q.ctrl.mode & ~ext_int_pin_n;
  assign setReq    = fallEdge | levelLow;
  assign heldNext  = fallEdge | (st_q.held & ~anyAck);
  assign latchNext = heldNext | levelLow;

  always_comb begin
    st_d       = st_q;
    st_d.ack   = req & mapped;
    st_d.err   = req & ~mapped;
    st_d.rdata = DATA_ZERO;
    // a new edge outranks a coincident acknowledge
    st_d.held       = heldNext;
    st_d.ctrl.latch = latchNext;
    if (wrAccess && wb_adr_i == STATUS_CONTROL_OFS) begin
      st_d.ctrl.mode = wb_dat_i[MODE_BIT];
      st_d.ctrl.mask = wb_dat_i[MASK_BIT];
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        STATUS_CONTROL_OFS: begin
          // acknowledge bit always reads zero
          st_d.rdata[MODE_BIT]    = st_q.ctrl.mode;
          st_d.rdata[MASK_BIT]    = st_q.ctrl.mask;
          st_d.rdata[PENDING_BIT] = st_q.ctrl.latch;
        end
        EVENT_STATUS_OFS: st_d.rdata[1:0] = evStatus;
        EVENT_MASK_OFS:   st_d.rdata[1:0] = evMask;
        VECTOR_OFS:       st_d.rdata = {VECTOR_HI_ADDR, VECTOR_LO_ADDR};
        default:          st_d.rdata = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q.ctrl.mode  <= MODE_RST;
      st_q.ctrl.mask  <= MASK_RST;
      st_q.ctrl.latch <= 1'b0;
      st_q.held       <= 1'b0;
      st_q.ack        <= 1'b0;
      st_q.err        <= 1'b0;
      st_q.rdata      <= DATA_ZERO;
    end else begin
      st_q <= st_d;
    end
  end

  assign evPulse[EV_LATCH_BIT] = latchNext & ~st_q.ctrl.latch;
  assign evPulse[EV_CLEAR_BIT] = ~latchNext & st_q.ctrl.latch;
  assign evClear = (wrAccess && wb_adr_i == EVENT_STATUS_OFS) ? wb_dat_i[1:0] : 2'h0;
  assign maskWe  = wrAccess & (wb_adr_i == EVENT_MASK_OFS);

  event_irq #(.N(EV_COUNT)) u_evt (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .eventIn   (evPulse),
    .clearOnes (evClear),
    .maskWe    (maskWe),
    .maskData  (wb_dat_i[1:0]),
    .statusQ   (evStatus),
    .maskQ     (evMask),
    .eventIrq  (eventIrq)
  );

  assign cpuIrqReq    = st_q.ctrl.latch & ~st_q.ctrl.mask;
  assign vectorHiAddr = VECTOR_HI_ADDR;
  assign vectorLoAddr = VECTOR_LO_ADDR;
  assign wb_ack_o     = st_q.ack;
  assign wb_err_o     = st_q.err;
  assign wb_dat_o     = st_q.rdata;

  chk_edge_sets_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
    fallEdge |=> st_q.ctrl.latch)
    else $error("falling edge did not latch");
  chk_vector_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
    vectorFetch && !setReq |=> !st_q.ctrl.latch)
    else $error("vector fetch did not clear latch");
  chk_soft_ack_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    swAck && !setReq |=> !st_q.ctrl.latch)
    else $error("software acknowledge did not clear latch");
  chk_reset_clears: assert property (@(posedge core_clk)
    sys_rst |=> !st_q.ctrl.latch && !st_q.ctrl.mode && !st_q.ctrl.mask)
    else $error("reset left control state set");
  chk_edge_mode_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !st_q.ctrl.mode && !fallEdge && !st_q.ctrl.latch |=> !st_q.ctrl.latch)
    else $error("edge mode latched without edge");
  chk_level_pending: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.ctrl.mode && !ext_int_pin_n |=> st_q.ctrl.latch)
    else $error("level mode dropped request with pin low");
  chk_mask_gates: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrAccess && wb_adr_i == STATUS_CONTROL_OFS && wb_dat_i[MASK_BIT] |=> !cpuIrqReq)
    else $error("request not gated by mask");
  chk_ack_reads_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    wb_ack_o |-> !wb_dat_o[ACK_BIT])
    else $error("acknowledge bit read as one");
  chk_break_blocks: assert property (@(posedge core_clk) disable iff (sys_rst)
    breakState && !break_clear_enable && !vectorFetch && st_q.held
    |=> st_q.held)
    else $error("latch cleared during protected break");
  chk_level_release: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.ctrl.mode && !st_q.held && ext_int_pin_n |=> !st_q.ctrl.latch)
    else $error("level request stayed after acknowledge and pin high");
  chk_pending_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
    wb_ack_o && $past(wb_adr_i) == STATUS_CONTROL_OFS && !$past(wb_we_i)
    |-> wb_dat_o[PENDING_BIT] == $past(st_q.ctrl.latch))
    else $error("pending flag mismatch");
endmodule

//--- verification/int_source.sv
// far side model: an open drain source on the interrupt pin
`timescale 1ns/1ps
module int_source (
  input  wire logic pullLow,       // request the pin low
  output logic      ext_int_pin_n  // pin as seen by the device
);
  // released pin rises to the internal pullup level
  assign ext_int_pin_n = pullLow ? 1'b0 : 1'b1;
endmodule

//--- verification/external_interrupt_latch_tb.sv
// self-checking bench for the external interrupt latch
`timescale 1ns/1ps
module external_interrupt_latch_tb;
  import ext_int_pkg::*;
  localparam logic [31:0] MODEW = 32'h0000_0001 << MODE_BIT;
  localparam logic [31:0] MASKW = 32'h0000_0001 << MASK_BIT;
  localparam logic [31:0] ACKW  = 32'h0000_0001 << ACK_BIT;
  localparam logic [31:0] PEND  = 32'h0000_0001 << PENDING_BIT;
  localparam logic [3:0]  SC    = STATUS_CONTROL_OFS;
  wb_req_t     req;
  logic        core_clk, sys_rst, wbAck, wbErr, gotErr, pin, pullLow;
  logic        vectorFetch, breakState, breakClr, cpuIrqReq, eventIrq;
  logic [31:0] wbDat, rd;
  logic [15:0] vHi, vLo;
  int          fail_count, n_tests;

  external_interrupt_latch i_external_interrupt_latch (
    .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
    .wb_dat_o(wbDat), .wb_ack_o(wbAck), .wb_err_o(wbErr), .ext_int_pin_n(pin),
    .vectorFetch(vectorFetch), .breakState(breakState), .break_clear_enable(breakClr),
    .cpuIrqReq(cpuIrqReq), .vectorHiAddr(vHi), .vectorLoAddr(vLo), .eventIrq(eventIrq));
  int_source i_int_source (.pullLow(pullLow), .ext_int_pin_n(pin));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one classic cycle, held until ack or err is sampled high
  task automatic wbCycle(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int i;
    @(posedge core_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: dat};
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (wbAck === 1'b1 || wbErr === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      tally_and_finish();
    end
    rd = wbDat;
    gotErr = wbErr;
    req <= '0;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    wbCycle(1'b1, adr, dat);
  endtask

  task automatic rdChk(input string what, input logic [3:0] adr, input logic [31:0] exp);
    wbCycle(1'b0, adr, DATA_ZERO);
    checkVal(what, exp, rd);
  endtask

  initial begin
    req = '0;
    pullLow = 1'b0;
    vectorFetch = 1'b0;
    breakState = 1'b0;
    breakClr = 1'b0;
    sys_rst = 1'b1;
    fail_count = 0;
    n_tests = 0;
    tick(2);
    sys_rst <= 1'b0;
    tick(2);
    rdChk("status reset", SC, DATA_ZERO);
    checkVal("vector high port", 32'(VECTOR_HI_ADDR), 32'(vHi));
    checkVal("vector low port", 32'(VECTOR_LO_ADDR), 32'(vLo));
    rdChk("vector reg", VECTOR_OFS, {VECTOR_HI_ADDR, VECTOR_LO_ADDR});
    wbCycle(1'b0, 4'h2, DATA_ZERO);
    checkVal("unmapped err", 32'(1), 32'(gotErr));
    $display("test reset done");
    wr(EVENT_MASK_OFS, 32'h0000_0003);
    pullLow <= 1'b1;
    tick(4);
    rdChk("edge pending", SC, PEND);
    checkVal("request out", 32'(1), 32'(cpuIrqReq));
    checkVal("event irq", 32'(1), 32'(eventIrq));
    wr(SC, ACKW);
    tick(4);
    rdChk("edge ack pin low", SC, DATA_ZERO);
    pullLow <= 1'b0;
    tick(2);
    pullLow <= 1'b1;
    tick(4);
    rdChk("fresh edge", SC, PEND);
    wr(SC, MASKW);
    rdChk("masked pending", SC, PEND | MASKW);
    checkVal("masked request", 32'(0), 32'(cpuIrqReq));
    vectorFetch <= 1'b1;
    tick(1);
    vectorFetch <= 1'b0;
    tick(2);
    rdChk("vector fetch", SC, MASKW);
    rdChk("event status", EVENT_STATUS_OFS, 32'h0000_0003);
    wr(EVENT_STATUS_OFS, 32'h0000_0003);
    tick(1);
    checkVal("event cleared", 32'(0), 32'(eventIrq));
    $display("test edge mode done");
    pullLow <= 1'b0;
    tick(2);
    wr(SC, MODEW);
    pullLow <= 1'b1;
    tick(4);
    wr(SC, MODEW | ACKW);
    tick(2);
    rdChk("level ack pin low", SC, MODEW | PEND);
    pullLow <= 1'b0;
    tick(4);
    rdChk("level ack then pin high", SC, MODEW);
    pullLow <= 1'b1;
    tick(4);
    pullLow <= 1'b0;
    tick(4);
    rdChk("level pin high no ack", SC, MODEW | PEND);
    wr(SC, MODEW | ACKW);
    tick(2);
    rdChk("level cleared", SC, MODEW);
    $display("test level mode done");
    wr(SC, DATA_ZERO);
    pullLow <= 1'b1;
    tick(4);
    breakState <= 1'b1;
    wr(SC, ACKW);
    rdChk("break blocked", SC, PEND);
    breakClr <= 1'b1;
    wr(SC, ACKW);
    breakState <= 1'b0;
    breakClr <= 1'b0;
    tick(2);
    rdChk("break cleared", SC, DATA_ZERO);
    $display("test break done");
    wr(SC, MODEW);
    tick(2);
    sys_rst <= 1'b1;
    tick(2);
    checkVal("request in reset", 32'(0), 32'(cpuIrqReq));
    sys_rst <= 1'b0;
    tick(4);
    rdChk("cleared with pin low", SC, DATA_ZERO);
    checkVal("request after reset", 32'(0), 32'(cpuIrqReq));
    $display("test reset pin low done");
    tally_and_finish();
  end
endmodule
